// [core/ppp_port.sv]
// Parallel programming port with fuse latching and nonvolatile storage
`include "ppp_defines.svh"
module ppp_port #(
  parameter int FLASH_WORDS = `PPP_FLASH_WORDS,
  parameter int FLASH_PAGE = `PPP_FLASH_PAGE,
  parameter int EE_BYTES = `PPP_EE_BYTES,
  parameter int EE_PAGE = `PPP_EE_PAGE,
  parameter int OP_CYC = `PPP_OP_CYC,
  // Identification values are arbitrary
  parameter logic [7:0] SIG0 = `PPP_SIG0,
  parameter logic [7:0] SIG1 = `PPP_SIG1,
  parameter logic [7:0] SIG2 = `PPP_SIG2,
  parameter logic [7:0] CAL = `PPP_CAL
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire ppp_pkg::ppp_pins_t pins,
  output logic [7:0] data_out,
  output logic data_oe_n,
  output logic ready_busy_n,
  output logic prog_mode,
  output ppp_pkg::ppp_fuses_t fuses,
  output logic [7:0] rc_trim_register
);
  import ppp_pkg::*;

  localparam int FAW = $clog2(FLASH_WORDS);
  localparam int FPW = $clog2(FLASH_PAGE);
  localparam int EAW = $clog2(EE_BYTES);
  localparam int EPW = $clog2(EE_PAGE);
  localparam logic [2:0] ENTRY_CYC = 3'(`PPP_ENTRY_CYC);
  localparam logic [2:0] MIN_TOG = 3'(`PPP_MIN_TOGGLES);

  // ========================================================================
  // Decoding shared by fuse reads and writes
  function automatic logic [1:0] fuse_sel(input logic bs2, input logic bs1);
    logic [1:0] s;
    s = `PPP_FSEL_LOW;
    if (bs2 && bs1) begin
      s = `PPP_FSEL_LOCK;
    end else if (bs2) begin
      s = `PPP_FSEL_EXT;
    end else if (bs1) begin
      s = `PPP_FSEL_HIGH;
    end
    return s;
  endfunction : fuse_sel

  // ========================================================================
  // Synchronised pins and edges
  ppp_pins_t p;
  ppp_pins_t p_q;
  ppp_sync #(.W($bits(ppp_pins_t))) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(pins),
    .q(p)
  );
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      p_q <= '0;
    end else begin
      p_q <= p;
    end
  end
  logic strobe_rise;
  logic strobe_chg;
  logic wr_fall;
  logic page_fall;
  logic hv_rise;
  assign strobe_rise = p.load_strobe && !p_q.load_strobe;
  assign strobe_chg = p.load_strobe != p_q.load_strobe;
  assign wr_fall = !p.wr_n && p_q.wr_n;
  assign page_fall = !p.byte_select_lo && p_q.byte_select_lo;
  assign hv_rise = p.reset_hv && !p_q.reset_hv;
  logic entry_pins_zero;
  assign entry_pins_zero = !p.pulse_action_bit1 && !p.pulse_action_bit0 &&
                           !p.byte_select_lo && !p.wr_n;

  // ========================================================================
  // Storage
  logic [15:0] flash_q [FLASH_WORDS];
  logic [7:0] ee_q [EE_BYTES];
  logic [15:0] fbuf_q [FLASH_PAGE];
  logic [7:0] ebuf_q [EE_PAGE];
  ppp_fuses_t live_q;
  ppp_fuses_t lat_q;
  logic [1:0] lock_q;
  logic [7:0] cmd_q;
  logic [7:0] addr_lo_q;
  logic [7:0] addr_hi_q;
  logic [7:0] dat_lo_q;
  logic [7:0] dat_hi_q;
  ppp_state_t state_q;
  logic [2:0] tog_q;
  logic [2:0] hold_q;
  logic [$clog2(OP_CYC+1)-1:0] busy_q;
  logic started_q;
  logic busy;
  logic in_prog;
  assign busy = busy_q != '0;
  assign in_prog = state_q == ST_PROG;

  logic [FAW-1:0] faddr;
  logic [EAW-1:0] eaddr;
  logic [FAW-FPW-1:0] fpage;
  logic [EAW-EPW-1:0] epage;
  assign faddr = FAW'({addr_hi_q, addr_lo_q});
  assign fpage = faddr[FAW-1:FPW];
  assign eaddr = addr_lo_q[EAW-1:0];
  assign epage = eaddr[EAW-1:EPW];

  logic fuse_lock;
  assign fuse_lock = !lock_q[`PPP_LOCK_ONE];
  logic mem_lock;
  assign mem_lock = !lock_q[`PPP_LOCK_ONE];
  logic read_lock;
  assign read_lock = lock_q == 2'h0;
  logic act_strobe;
  assign act_strobe = in_prog && !busy && strobe_rise;
  logic start_op;
  assign start_op = in_prog && !busy && wr_fall;

  // ========================================================================
  // Programming-mode entry
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tog_q <= '0;
    end else if (p.reset_pin_low && !p.reset_hv) begin
      if (strobe_chg && tog_q != MIN_TOG) begin
        tog_q <= tog_q + 3'h1;
      end
    end else if (!p.reset_hv) begin
      tog_q <= '0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_NORMAL;
      hold_q <= '0;
    end else begin
      case (state_q)
        ST_NORMAL: begin
          hold_q <= '0;
          if (hv_rise) begin
            if (entry_pins_zero && tog_q == MIN_TOG) begin
              state_q <= ST_ARMED;
            end else begin
              state_q <= ST_REFUSED;
            end
          end
        end
        ST_ARMED: begin
          if (!entry_pins_zero || !p.reset_hv) begin
            state_q <= ST_REFUSED;
          end else if (hold_q == ENTRY_CYC - 3'h1) begin
            state_q <= ST_PROG;
          end else begin
            hold_q <= hold_q + 3'h1;
          end
        end
        ST_PROG: begin
          if (!p.reset_hv) begin
            state_q <= ST_NORMAL;
          end
        end
        ST_REFUSED: begin
          if (!p.reset_hv) begin
            state_q <= ST_NORMAL;
          end
        end
        default: begin
          state_q <= ST_NORMAL;
        end
      endcase
    end
  end

  // ========================================================================
  // Command, address and data loading
  // action select on strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_q <= '0;
      addr_lo_q <= '0;
      addr_hi_q <= '0;
      dat_lo_q <= '0;
      dat_hi_q <= '0;
    end else if (act_strobe) begin
      case ({p.pulse_action_bit1, p.pulse_action_bit0})
        `PPP_ACT_ADDR: begin
          if (p.byte_select_lo) begin
            addr_hi_q <= p.data;
          end else begin
            addr_lo_q <= p.data;
          end
        end
        `PPP_ACT_DATA: begin
          if (p.byte_select_lo) begin
            dat_hi_q <= p.data;
          end else begin
            dat_lo_q <= p.data;
          end
        end
        `PPP_ACT_CMD: begin
          cmd_q <= p.data;
        end
        default: begin
          cmd_q <= cmd_q;
        end
      endcase
    end
  end

  // ========================================================================
  // Page buffers, loaded as byte select falls
  // byte select doubles as page load
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < FLASH_PAGE; i++) begin
        fbuf_q[i] <= 16'hffff;
      end
      for (int i = 0; i < EE_PAGE; i++) begin
        ebuf_q[i] <= 8'hff;
      end
    end else if (in_prog && !busy && page_fall) begin
      if (cmd_q == `PPP_CMD_WR_FLASH) begin
        fbuf_q[faddr[FPW-1:0]] <= {dat_hi_q, dat_lo_q};
      end else if (cmd_q == `PPP_CMD_WR_EE) begin
        ebuf_q[eaddr[EPW-1:0]] <= dat_lo_q;
      end
    end
  end

  // ========================================================================
  // Nonvolatile arrays; reset stands in for the erased state
  // write command decode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < FLASH_WORDS; i++) begin
        flash_q[i] <= 16'hffff;
      end
    end else if (start_op) begin
      if (cmd_q == `PPP_CMD_ERASE) begin
        for (int i = 0; i < FLASH_WORDS; i++) begin
          flash_q[i] <= 16'hffff;
        end
      end else if (cmd_q == `PPP_CMD_WR_FLASH && !mem_lock) begin
        for (int i = 0; i < FLASH_PAGE; i++) begin
          flash_q[{fpage, FPW'(i)}] <= fbuf_q[i];
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < EE_BYTES; i++) begin
        ee_q[i] <= 8'hff;
      end
    end else if (start_op) begin
      if (cmd_q == `PPP_CMD_ERASE && live_q.high[`PPP_HF_KEEP]) begin
        for (int i = 0; i < EE_BYTES; i++) begin
          ee_q[i] <= 8'hff;
        end
      end else if (cmd_q == `PPP_CMD_WR_EE && !mem_lock) begin
        for (int i = 0; i < EE_PAGE; i++) begin
          ee_q[{epage, EPW'(i)}] <= ebuf_q[i];
        end
      end
    end
  end

  // ========================================================================
  // Lock bits and live fuses
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_q <= `PPP_LOCK_RST;
    end else if (start_op && cmd_q == `PPP_CMD_ERASE) begin
      lock_q <= `PPP_LOCK_RST;
    end else if (start_op && cmd_q == `PPP_CMD_WR_LOCK) begin
      // Lock bits only program; erase alone clears them
      lock_q <= lock_q & dat_lo_q[1:0];
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      live_q.low <= `PPP_LOW_FUSE_RST;
      live_q.high <= `PPP_HIGH_FUSE_RST;
      live_q.ext <= `PPP_EXT_FUSE_RST;
    end else if (start_op && cmd_q == `PPP_CMD_WR_FUSE && !fuse_lock) begin
      case (fuse_sel(p.pulse_action_bit1, p.byte_select_lo))
        `PPP_FSEL_LOW: begin
          live_q.low <= dat_lo_q;
        end
        `PPP_FSEL_HIGH: begin
          live_q.high <= dat_lo_q;
        end
        `PPP_FSEL_EXT: begin
          live_q.ext <= dat_lo_q;
        end
        default: begin
          live_q <= live_q;
        end
      endcase
    end
  end

  // ========================================================================
  // Fuse latching
  logic leave_prog;
  logic enter_prog;
  assign enter_prog = state_q == ST_ARMED && entry_pins_zero &&
                      p.reset_hv && hold_q == ENTRY_CYC - 3'h1;
  assign leave_prog = in_prog && !p.reset_hv;
  // latch at power-up, entry and exit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      started_q <= 1'b0;
      lat_q <= '1;
    end else begin
      started_q <= 1'b1;
      if (!started_q || enter_prog || leave_prog) begin
        lat_q <= live_q;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fuses <= '1;
    end else begin
      fuses <= lat_q;
      fuses.high[`PPP_HF_KEEP] <= lat_q.high[`PPP_HF_KEEP] &
                                  live_q.high[`PPP_HF_KEEP];
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rc_trim_register <= CAL;
    end
  end

  // ========================================================================
  // Busy timing
  // busy from write pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q <= '0;
      ready_busy_n <= 1'b1;
    end else begin
      if (start_op) begin
        busy_q <= ($bits(busy_q))'(OP_CYC);
      end else if (busy) begin
        busy_q <= busy_q - 1'b1;
      end
      ready_busy_n <= !(start_op || busy_q > 1);
    end
  end

  // ========================================================================
  // Read path
  logic [7:0] rd_byte;
  logic [15:0] fword;
  assign fword = flash_q[faddr];
  always_comb begin
    rd_byte = 8'hff;
    case (cmd_q)
      `PPP_CMD_RD_SIG: begin
        if (p.byte_select_lo) begin
          rd_byte = CAL;
        end else if (addr_lo_q[1:0] == 2'h0) begin
          rd_byte = SIG0;
        end else if (addr_lo_q[1:0] == 2'h1) begin
          rd_byte = SIG1;
        end else if (addr_lo_q[1:0] == 2'h2) begin
          rd_byte = SIG2;
        end
      end
      `PPP_CMD_RD_FUSE: begin
        case (fuse_sel(p.pulse_action_bit1, p.byte_select_lo))
          `PPP_FSEL_LOW: rd_byte = live_q.low;
          `PPP_FSEL_HIGH: rd_byte = live_q.high;
          `PPP_FSEL_EXT: rd_byte = live_q.ext;
          default: rd_byte = {6'h3f, lock_q};
        endcase
      end
      `PPP_CMD_RD_FLASH: begin
        if (!read_lock) begin
          rd_byte = p.byte_select_lo ? fword[15:8] : fword[7:0];
        end
      end
      `PPP_CMD_RD_EE: begin
        if (!read_lock) begin
          rd_byte = ee_q[eaddr];
        end
      end
      default: begin
        rd_byte = 8'hff;
      end
    endcase
  end
  // drive only while output enable low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_out <= '0;
      data_oe_n <= 1'b1;
    end else begin
      data_oe_n <= !(in_prog && !p.oe_n);
      data_out <= rd_byte;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prog_mode <= 1'b0;
    end else begin
      prog_mode <= in_prog;
    end
  end
endmodule : ppp_port

// [core/ppp_defines.svh]
// Constants for the parallel programming port and configuration fuses
`ifndef PPP_DEFINES_SVH
`define PPP_DEFINES_SVH
// ==========================================================================
// Pin actions and commands
`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2
`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_WR_FUSE 8'h40
`define PPP_CMD_WR_LOCK 8'h20
`define PPP_CMD_WR_FLASH 8'h10
`define PPP_CMD_WR_EE 8'h11
`define PPP_CMD_RD_SIG 8'h08
`define PPP_CMD_RD_FUSE 8'h04
`define PPP_CMD_RD_FLASH 8'h02
`define PPP_CMD_RD_EE 8'h03
// ==========================================================================
// Fuse layout and defaults
`define PPP_LOW_FUSE_RST 8'h62
`define PPP_HIGH_FUSE_RST 8'hdf
`define PPP_EXT_FUSE_RST 8'hff
`define PPP_HF_KEEP 6
`define PPP_LOCK_ONE 0
`define PPP_LOCK_RST 2'h3
`define PPP_FSEL_LOW 2'h0
`define PPP_FSEL_HIGH 2'h1
`define PPP_FSEL_EXT 2'h2
`define PPP_FSEL_LOCK 2'h3
// ==========================================================================
// Geometry and timing
`define PPP_FLASH_WORDS 1024
`define PPP_FLASH_PAGE 16
`define PPP_EE_BYTES 128
`define PPP_EE_PAGE 4
`define PPP_CLK_NS 20
`define PPP_ENTRY_HOLD_NS 100
`define PPP_ENTRY_CYC ((`PPP_ENTRY_HOLD_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS)
`define PPP_MIN_TOGGLES 6
`define PPP_OP_CYC 32
// Identification and trim values are arbitrary
`define PPP_SIG0 8'h5a
`define PPP_SIG1 8'h01
`define PPP_SIG2 8'h02
`define PPP_CAL 8'h80
`endif

// [core/ppp_pkg.sv]
// Types shared by the programming port files
package ppp_pkg;
  // ========================================================================
  // Pin group and fuse carriers
  typedef struct packed {
    logic reset_hv;
    logic reset_pin_low;
    logic load_strobe;
    logic pulse_action_bit1;
    logic pulse_action_bit0;
    logic byte_select_lo;
    logic wr_n;
    logic oe_n;
    logic [7:0] data;
  } ppp_pins_t;
  typedef struct packed {
    logic [7:0] ext;
    logic [7:0] high;
    logic [7:0] low;
  } ppp_fuses_t;
  typedef enum logic [1:0] {
    ST_NORMAL, ST_ARMED, ST_PROG, ST_REFUSED
  } ppp_state_t;
endpackage : ppp_pkg

// [core/ppp_sync.sv]
// Three-flop pin synchroniser with agreement filter
module ppp_sync #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  // ========================================================================
  // Stages; only the second flop reads the first
  always_ff @(posedge clk) begin
    s1_q <= d;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end
  // ========================================================================
  // A bit changes once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          q[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          q[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule : ppp_sync

// [dv/ppp_port_assertions.sv]
// Port checker for the parallel programming port
module ppp_port_assertions #(
  parameter int OP_CYC = 32,
  parameter logic [7:0] CAL = 8'h80
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire ppp_pkg::ppp_pins_t pins,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  input wire logic ready_busy_n,
  input wire logic prog_mode,
  input wire ppp_pkg::ppp_fuses_t fuses,
  input wire logic [7:0] rc_trim_register
);
  timeunit 1ns;
  timeprecision 100ps;
  import ppp_pkg::*;
  // ==========================================================
  // Helpers
  int busy_q;
  logic entry_zero;
  logic [22:0] frozen;
  assign entry_zero = ~|{pins.pulse_action_bit1, pins.pulse_action_bit0,
    pins.byte_select_lo, pins.wr_n};
  // Keep fuse left out, it acts at once
  assign frozen = {fuses.ext, fuses.high[7], fuses.high[5:0], fuses.low};
  always_ff @(posedge clk) begin
    if (!rst_n || ready_busy_n) begin
      busy_q <= 0;
    end else begin
      busy_q <= busy_q + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Assertions
  oe_release_a: assert property (pins.oe_n [*8] |=> data_oe_n)
    else $error("bus driven with output enable high");
  oe_drive_a: assert property ((prog_mode && !pins.oe_n) [*8]
    |=> !data_oe_n)
    else $error("bus not driven during read");
  trim_reset_a: assert property ($rose(rst_n) |-> rc_trim_register == CAL)
    else $error("trim not loaded in reset");
  fuse_default_a: assert property ($rose(rst_n) |-> ##[1:3]
    fuses == {8'hff, 8'hdf, 8'h62})
    else $error("fuse defaults wrong");
  busy_len_a: assert property ($rose(ready_busy_n)
    |-> busy_q inside {[OP_CYC-2:OP_CYC]})
    else $error("busy length wrong");
  busy_bound_a: assert property (busy_q <= OP_CYC)
    else $error("busy never ends");
  busy_cause_a: assert property ($fell(ready_busy_n)
    |-> prog_mode && !pins.wr_n)
    else $error("busy without write pulse");
  entry_hv_a: assert property ($rose(prog_mode)
    |-> pins.reset_hv && $past(pins.reset_hv, 8))
    else $error("entry without high voltage");
  exit_hv_a: assert property (!pins.reset_hv [*8] |=> !prog_mode)
    else $error("mode held without high voltage");
  entry_pins_a: assert property ($rose(prog_mode)
    |-> $past(entry_zero, 7) && $past(entry_zero, 8))
    else $error("entry with entry pins moving");
  fuse_latch_a: assert property (prog_mode && pins.reset_hv
    |=> $stable(frozen))
    else $error("latched fuses changed in mode");
endmodule : ppp_port_assertions

bind ppp_port ppp_port_assertions #(.OP_CYC(OP_CYC), .CAL(CAL))
  u_ppp_port_assertions (.clk(clk), .rst_n(rst_n), .pins(pins),
  .data_out(data_out), .data_oe_n(data_oe_n),
  .ready_busy_n(ready_busy_n), .prog_mode(prog_mode), .fuses(fuses),
  .rc_trim_register(rc_trim_register));

// [dv/ppp_prog.sv]
// Programmer model driving the parallel programming pins
module ppp_prog (
  input wire logic clk,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  input wire logic ready_busy_n,
  output ppp_pkg::ppp_pins_t pins
);
  timeunit 1ns;
  timeprecision 100ps;
  import ppp_pkg::*;
  ppp_pins_t ctl = '{wr_n: 1'b1, oe_n: 1'b1, default: '0};
  assign pins = {ctl[15:8], !data_oe_n ? data_out :
    (ctl.oe_n ? ctl.data : ~ctl.data)};
  // ==========================================================
  // Pin tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc
  task automatic entry(input bit bad);
    ctl.reset_pin_low = 1'b1;
    repeat (12) begin
      ctl.load_strobe = !ctl.load_strobe;
      cyc(16);
    end
    {ctl.pulse_action_bit1, ctl.pulse_action_bit0} = 2'h0;
    {ctl.byte_select_lo, ctl.wr_n} = 2'h0;
    cyc(8);
    {ctl.reset_pin_low, ctl.reset_hv} = 2'h1;
    if (bad) begin
      cyc(1);
      ctl.pulse_action_bit0 = 1'b1;
      cyc(3);
      ctl.pulse_action_bit0 = 1'b0;
    end
    cyc(2600);
    ctl.wr_n = 1'b1;
    cyc(16);
  endtask : entry
  task automatic leave();
    ctl.reset_hv = 1'b0;
    cyc(40);
  endtask : leave
  task automatic load(input logic [1:0] a, input logic b,
    input logic [7:0] d);
    {ctl.pulse_action_bit1, ctl.pulse_action_bit0} = a;
    ctl.byte_select_lo = b;
    ctl.data = d;
    cyc(16);
    ctl.load_strobe = 1'b1;
    cyc(16);
    ctl.load_strobe = 1'b0;
    cyc(16);
  endtask : load
  task automatic page_buffer_strobe();
    ctl.byte_select_lo = 1'b1;
    cyc(16);
    ctl.byte_select_lo = 1'b0;
    cyc(16);
  endtask : page_buffer_strobe
  task automatic write(input logic x1, input logic b, output bit busy);
    int n;
    {ctl.pulse_action_bit1, ctl.pulse_action_bit0} = {x1, 1'b0};
    ctl.byte_select_lo = b;
    cyc(16);
    ctl.wr_n = 1'b0;
    cyc(16);
    busy = (ready_busy_n === 1'b0);
    ctl.wr_n = 1'b1;
    n = 0;
    while (ready_busy_n !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    cyc(16);
  endtask : write
  task automatic read(input logic x1, input logic b, output logic [7:0] d);
    {ctl.pulse_action_bit1, ctl.pulse_action_bit0} = {x1, 1'b0};
    ctl.byte_select_lo = b;
    ctl.oe_n = 1'b0;
    cyc(16);
    d = pins.data;
    ctl.oe_n = 1'b1;
    cyc(16);
  endtask : read
endmodule : ppp_prog

// [dv/ppp_port_bench.sv]
// Self-checking bench for the parallel programming port
module ppp_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import ppp_pkg::*;
  // Arbitrary identification and trim values
  localparam logic [7:0] SG[3] = '{8'h3c, 8'h4d, 8'h5e};
  localparam logic [7:0] CB = 8'h6b;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  bit busy;
  ppp_pins_t pins;
  logic [7:0] data_out;
  logic data_oe_n;
  logic ready_busy_n;
  logic prog_mode;
  ppp_fuses_t fuses;
  logic [7:0] rc_trim_register;
  always #10 clk = !clk;
  ppp_port #(.SIG0(SG[0]), .SIG1(SG[1]), .SIG2(SG[2]), .CAL(CB))
    u_ppp_port (.clk(clk), .rst_n(rst_n), .pins(pins),
    .data_out(data_out), .data_oe_n(data_oe_n),
    .ready_busy_n(ready_busy_n), .prog_mode(prog_mode), .fuses(fuses),
    .rc_trim_register(rc_trim_register));
  ppp_prog u_ppp_prog (.clk(clk), .data_out(data_out),
    .data_oe_n(data_oe_n), .ready_busy_n(ready_busy_n), .pins(pins));
  // ==========================================================
  // Helpers
  task automatic chk(input logic [23:0] got, input logic [23:0] exp,
    input string msg);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk
  task automatic rd_chk(input logic x1, input logic b,
    input logic [7:0] exp, input string msg);
    logic [7:0] d;
    u_ppp_prog.read(x1, b, d);
    chk(d, exp, msg);
  endtask : rd_chk
  task automatic cmd(input logic [7:0] c);
    u_ppp_prog.load(2'h2, 1'b0, c);
  endtask : cmd
  task automatic addr(input logic b, input logic [7:0] a);
    u_ppp_prog.load(2'h0, b, a);
  endtask : addr
  task automatic dat(input logic b, input logic [7:0] d);
    u_ppp_prog.load(2'h1, b, d);
  endtask : dat
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  // Ceiling well above the ~9k cycles of the run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      wrap_up();
    end
  end
  // ==========================================================
  // Tests
  task automatic t_reset();
    chk(rc_trim_register, CB, "trim");
    chk(fuses, 24'hffdf62, "fuse defaults");
    chk({prog_mode, ready_busy_n, data_oe_n}, 3'h3, "idle");
    $display("Test reset done");
  endtask : t_reset
  task automatic t_refuse();
    u_ppp_prog.entry(1'b1);
    chk(prog_mode, 1'b0, "disturbed entry");
    u_ppp_prog.leave();
    $display("Test refuse done");
  endtask : t_refuse
  task automatic t_ident();
    u_ppp_prog.entry(1'b0);
    chk(prog_mode, 1'b1, "entry");
    cmd(8'h08);
    for (int i = 0; i < 3; i++) begin
      addr(1'b0, 8'(i));
      rd_chk(1'b0, 1'b0, SG[i], "ident byte");
    end
    rd_chk(1'b0, 1'b1, CB, "trim byte");
    cmd(8'h04);
    rd_chk(1'b0, 1'b0, 8'h62, "low fuse");
    rd_chk(1'b0, 1'b1, 8'hdf, "high fuse");
    rd_chk(1'b1, 1'b0, 8'hff, "ext fuse");
    $display("Test ident done");
  endtask : t_ident
  task automatic t_flash();
    cmd(8'h10);
    addr(1'b0, 8'h35);
    dat(1'b0, 8'hc3);
    dat(1'b1, 8'ha5);
    u_ppp_prog.page_buffer_strobe();
    addr(1'b1, 8'h02);
    u_ppp_prog.write(1'b0, 1'b1, busy);
    chk(busy, 1'b1, "page write busy");
    cmd(8'h02);
    rd_chk(1'b0, 1'b0, 8'hc3, "flash low");
    rd_chk(1'b0, 1'b1, 8'ha5, "flash high");
    u_ppp_prog.load(2'h3, 1'b0, 8'h80);
    rd_chk(1'b0, 1'b0, 8'hc3, "idle action");
    addr(1'b0, 8'h34);
    rd_chk(1'b0, 1'b0, 8'hff, "word in page");
    addr(1'b1, 8'h00);
    addr(1'b0, 8'h35);
    rd_chk(1'b0, 1'b0, 8'hff, "page bits");
    $display("Test flash done");
  endtask : t_flash
  task automatic t_ee();
    cmd(8'h11);
    addr(1'b0, 8'h4b);
    dat(1'b0, 8'h96);
    u_ppp_prog.page_buffer_strobe();
    u_ppp_prog.write(1'b0, 1'b0, busy);
    cmd(8'h03);
    rd_chk(1'b0, 1'b0, 8'h96, "eeprom byte");
    $display("Test eeprom done");
  endtask : t_ee
  task automatic t_fuse();
    cmd(8'h40);
    dat(1'b0, 8'h9f);
    u_ppp_prog.write(1'b0, 1'b1, busy);
    chk(fuses.high, 8'h9f, "keep fuse live");
    dat(1'b0, 8'h64);
    u_ppp_prog.write(1'b0, 1'b0, busy);
    chk(fuses.low, 8'h62, "latched low");
    cmd(8'h04);
    rd_chk(1'b0, 1'b0, 8'h64, "low written");
    cmd(8'h80);
    u_ppp_prog.write(1'b0, 1'b0, busy);
    cmd(8'h03);
    rd_chk(1'b0, 1'b0, 8'h96, "eeprom kept");
    cmd(8'h02);
    addr(1'b1, 8'h02);
    addr(1'b0, 8'h35);
    rd_chk(1'b0, 1'b0, 8'hff, "flash erased");
    cmd(8'h04);
    rd_chk(1'b0, 1'b0, 8'h64, "fuse on erase");
    cmd(8'h20);
    dat(1'b0, 8'hfe);
    u_ppp_prog.write(1'b0, 1'b0, busy);
    cmd(8'h40);
    dat(1'b0, 8'h00);
    u_ppp_prog.write(1'b0, 1'b0, busy);
    cmd(8'h04);
    rd_chk(1'b0, 1'b0, 8'h64, "locked fuse");
    rd_chk(1'b1, 1'b1, 8'hfe, "lock bits");
    cmd(8'h08);
    addr(1'b0, 8'h01);
    rd_chk(1'b0, 1'b0, SG[1], "ident locked");
    u_ppp_prog.leave();
    chk(fuses.low, 8'h64, "latch on exit");
    $display("Test fuse done");
  endtask : t_fuse
  initial begin
    repeat (20) @(posedge clk);
    #2;
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #2;
    t_reset();
    t_refuse();
    t_ident();
    t_flash();
    t_ee();
    t_fuse();
    wrap_up();
  end
endmodule : ppp_port_bench
